//--- design/checksum_offload_pkg.sv
// Operation
// - Bit 16 enables transmit engine, resets 0
// - Bit 0 enables receive engine, resets 0
// - Mode 0 starts checksum at byte 14
// - Mode 1 starts checksum at layer-3 start
package checksum_offload_pkg;

   // Register map
   localparam logic [11:0] CHECKSUM_OFFLOAD_CONTROL_ADDR = 12'h130;
   localparam int          TX_ENABLE_BIT                 = 16;
   localparam int          RX_ENABLE_BIT                 = 0;
   localparam int          RX_MODE_BIT                   = 1;
   localparam logic        ENABLE_RESET                  = 1'h0;
   localparam logic        MODE_RESET                    = 1'h0;

   // Frame layout
   localparam logic [7:0]  FIXED_START_OFFSET            = 8'h0e;
   localparam logic [7:0]  VLAN_TAG_BYTES                = 8'h04;
   localparam logic [7:0]  SNAP_HEADER_BYTES             = 8'h08;
   localparam logic [15:0] VLAN_TPID                     = 16'h8100;
   localparam logic [15:0] SNAP_LENGTH_LIMIT             = 16'h0600;
   localparam logic [7:0]  TYPE_FIELD_OFFSET             = 8'h0c;

   // Register port request
   typedef struct packed
   {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_type;

   // Per-frame configuration handed to the engines
   typedef struct packed
   {
      logic       tx_enable;
      logic       rx_enable;
      logic       rx_l3_mode;
      logic [7:0] rx_start;
   } frame_cfg_type;

endpackage

//--- design/rx_start_finder.sv
`timescale 1ns/1ns
// Finds the receive checksum start offset from the first frame bytes
module rx_start_finder
   import checksum_offload_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Receive byte stream
   input  wire logic       sof,
   input  wire logic       byte_valid,
   input  wire logic [7:0] byte_data,
   // Layer-3 start offset for the current frame
   output      logic [7:0] l3_start
);

   typedef struct packed
   {
      logic [7:0]  count;
      logic [15:0] type_field;
      logic [7:0]  type_pos;
      logic [7:0]  start;
   } find_state_type;

   find_state_type st_reg;
   find_state_type st_next;
   find_state_type base;
   logic [15:0]    word;

   // Walk the type field, skipping VLAN tags and SNAP headers
   always_comb
   begin
      st_next = st_reg;
      word    = {st_reg.type_field[7:0], byte_data};
      base    = st_reg;
      // A frame start restarts the walk, also for a byte in the same cycle
      if (sof)
      begin
         base.count    = 8'h00;
         base.type_pos = TYPE_FIELD_OFFSET;
         base.start    = FIXED_START_OFFSET;
         st_next       = base;
      end
      if (byte_valid)
      begin
         // Count saturates so a long payload never looks like a header again
         if (!(&base.count))
            st_next.count = base.count + 8'h01;
         st_next.type_field = word;
         if (base.count == base.type_pos + 8'h01)
         begin
            if (word == VLAN_TPID)
            begin
               st_next.type_pos = base.type_pos + VLAN_TAG_BYTES;
               st_next.start    = base.start + VLAN_TAG_BYTES;
            end
            else if (word < SNAP_LENGTH_LIMIT)
               st_next.start = base.start + SNAP_HEADER_BYTES;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '{count: 8'h00, type_field: 16'h0000, type_pos: TYPE_FIELD_OFFSET,
                     start: FIXED_START_OFFSET};
      else
         st_reg <= st_next;
   end

   assign l3_start = st_reg.start;

endmodule // rx_start_finder

//--- design/checksum_offload_control.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
// Control register for the transmit and receive checksum engines
module checksum_offload_control
   import checksum_offload_pkg::*;
(
   // Clock and reset
   input  wire logic        MCLK,
   input  wire logic        RSTN,
   // Register port
   input  wire logic [11:0] ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output      logic [31:0] RDATA,
   // Frame boundaries and receive bytes from the data paths
   input  wire logic        TX_SOF,
   input  wire logic        RX_SOF,
   input  wire logic        RX_BYTE_VALID,
   input  wire logic [7:0]  RX_BYTE,
   // Configuration seen by the engines
   output      logic        TX_ENGINE_ENABLE,
   output      logic        RX_ENGINE_ENABLE,
   output      logic        RX_L3_MODE,
   output      logic [7:0]  RX_CHECKSUM_START
);

   typedef struct packed
   {
      logic          tx_en_sw;
      logic          rx_en_sw;
      logic          rx_mode_sw;
      logic [31:0]   rdata;
      frame_cfg_type cfg;
      logic          rx_hdr_pending;
   } ctrl_state_type;

   ctrl_state_type st_reg;
   ctrl_state_type st_next;
   reg_req_type    req;
   logic [7:0]     l3_start;
   logic [31:0]    readback;

   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   // Header parser gives the layer-3 offset
   rx_start_finder u_finder
   (
      .clk        (MCLK),
      .rst_n      (RSTN),
      .sof        (RX_SOF),
      .byte_valid (RX_BYTE_VALID),
      .byte_data  (RX_BYTE),
      .l3_start   (l3_start)
   );

   // Register image; reserved bits read zero
   always_comb
   begin
      readback                = 32'h0000_0000;
      readback[TX_ENABLE_BIT] = st_reg.tx_en_sw;
      readback[RX_ENABLE_BIT] = st_reg.rx_en_sw;
      readback[RX_MODE_BIT]   = st_reg.rx_mode_sw;
   end

   // Register writes, reads and frame-boundary sampling
   always_comb
   begin
      st_next       = st_reg;
      st_next.rdata = 32'h0000_0000;
      if (req.wr && req.addr == CHECKSUM_OFFLOAD_CONTROL_ADDR)
      begin
         st_next.tx_en_sw   = req.wdata[TX_ENABLE_BIT];
         st_next.rx_en_sw   = req.wdata[RX_ENABLE_BIT];
         st_next.rx_mode_sw = req.wdata[RX_MODE_BIT];
      end
      if (req.rd && req.addr == CHECKSUM_OFFLOAD_CONTROL_ADDR)
         st_next.rdata = readback;
      // Transmit setting is latched only when a frame begins
      if (TX_SOF)
         st_next.cfg.tx_enable = st_reg.tx_en_sw;
      if (RX_SOF)
      begin
         st_next.cfg.rx_enable      = st_reg.rx_en_sw;
         st_next.cfg.rx_l3_mode     = st_reg.rx_mode_sw;
         st_next.cfg.rx_start       = FIXED_START_OFFSET;
         st_next.rx_hdr_pending     = st_reg.rx_mode_sw;
      end
      // In layer-3 mode the offset follows the parser until the next receive frame start
      else if (st_reg.rx_hdr_pending)
         st_next.cfg.rx_start = l3_start;
   end

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         st_reg            <= '0;
         st_reg.tx_en_sw   <= ENABLE_RESET;
         st_reg.rx_en_sw   <= ENABLE_RESET;
         st_reg.rx_mode_sw <= MODE_RESET;
         st_reg.cfg.rx_start <= FIXED_START_OFFSET;
      end
      else
         st_reg <= st_next;
   end

   assign RDATA             = st_reg.rdata;
   assign TX_ENGINE_ENABLE  = st_reg.cfg.tx_enable;
   assign RX_ENGINE_ENABLE  = st_reg.cfg.rx_enable;
   assign RX_L3_MODE        = st_reg.cfg.rx_l3_mode;
   assign RX_CHECKSUM_START = st_reg.cfg.rx_start;

   // Engine enable follows software only at a frame start
   a_tx_enable_hold: assert property (@(posedge MCLK) disable iff (!RSTN)
      !$past(TX_SOF) |-> $stable(TX_ENGINE_ENABLE))
      else $error("transmit enable changed inside a frame");

   // Receive enable and mode stay put between receive frame starts
   a_rx_enable_hold: assert property (@(posedge MCLK) disable iff (!RSTN)
      !$past(RX_SOF) |-> ($stable(RX_ENGINE_ENABLE) && $stable(RX_L3_MODE)))
      else $error("receive setting changed inside a frame");

   // Transmit enable copies the software bit of the start edge
   a_tx_enable_take: assert property (@(posedge MCLK) disable iff (!RSTN)
      TX_SOF |=> TX_ENGINE_ENABLE == $past(st_reg.tx_en_sw))
      else $error("transmit enable not taken at frame start");

   // Receive enable copies the software bit of the start edge
   a_rx_enable_take: assert property (@(posedge MCLK) disable iff (!RSTN)
      RX_SOF |=> RX_ENGINE_ENABLE == $past(st_reg.rx_en_sw))
      else $error("receive enable not taken at frame start");

   // Receive start mode copies the software bit of the start edge
   a_rx_mode_take: assert property (@(posedge MCLK) disable iff (!RSTN)
      RX_SOF |=> RX_L3_MODE == $past(st_reg.rx_mode_sw))
      else $error("receive start mode not taken at frame start");

   // Fixed mode always reports the fourteen byte offset
   a_fixed_start: assert property (@(posedge MCLK) disable iff (!RSTN)
      !RX_L3_MODE |-> RX_CHECKSUM_START == FIXED_START_OFFSET)
      else $error("fixed start offset not fourteen");

   // Every receive frame opens at the fixed offset
   a_start_at_sof: assert property (@(posedge MCLK) disable iff (!RSTN)
      RX_SOF |=> RX_CHECKSUM_START == FIXED_START_OFFSET)
      else $error("start offset not reloaded at frame start");

   // Layer-3 mode never starts before the fixed offset
   a_l3_start_min: assert property (@(posedge MCLK) disable iff (!RSTN)
      RX_L3_MODE |-> RX_CHECKSUM_START >= FIXED_START_OFFSET)
      else $error("layer-3 start below fixed offset");

   // Layer-3 offset grows by one tag or one SNAP header at a time
   a_start_step: assert property (@(posedge MCLK) disable iff (!RSTN)
      RX_L3_MODE && !$past(RX_SOF) && !$stable(RX_CHECKSUM_START) |->
         (RX_CHECKSUM_START - $past(RX_CHECKSUM_START) == VLAN_TAG_BYTES ||
          RX_CHECKSUM_START - $past(RX_CHECKSUM_START) == SNAP_HEADER_BYTES))
      else $error("layer-3 start moved by an illegal step");

   // Header tracking is armed only in layer-3 mode
   a_pending_mode: assert property (@(posedge MCLK) disable iff (!RSTN)
      !RX_L3_MODE |-> !st_reg.rx_hdr_pending)
      else $error("header tracking armed in fixed mode");

   sequence write_reg_s;
      WR && ADDR == CHECKSUM_OFFLOAD_CONTROL_ADDR;
   endsequence

   sequence read_reg_s;
      RD && ADDR == CHECKSUM_OFFLOAD_CONTROL_ADDR && !WR;
   endsequence

   sequence stray_write_s;
      WR && ADDR != CHECKSUM_OFFLOAD_CONTROL_ADDR;
   endsequence

   sequence stray_read_s;
      RD && ADDR != CHECKSUM_OFFLOAD_CONTROL_ADDR && !WR;
   endsequence

   // A write to the register lands in the software copy of the transmit enable and start mode bits
   a_write_lands: assert property (@(posedge MCLK) disable iff (!RSTN)
      write_reg_s |=> st_reg.tx_en_sw == $past(WDATA[TX_ENABLE_BIT]) &&
                      st_reg.rx_mode_sw == $past(WDATA[RX_MODE_BIT]))
      else $error("register write did not land");

   // Write then read returns the transmit enable bit
   a_write_readback: assert property (@(posedge MCLK) disable iff (!RSTN)
      write_reg_s ##1 read_reg_s |=> RDATA[TX_ENABLE_BIT] == $past(WDATA[TX_ENABLE_BIT], 2))
      else $error("transmit enable readback wrong");

   // Write then read returns the receive enable bit
   a_rx_readback: assert property (@(posedge MCLK) disable iff (!RSTN)
      write_reg_s ##1 read_reg_s |=> RDATA[RX_ENABLE_BIT] == $past(WDATA[RX_ENABLE_BIT], 2))
      else $error("receive enable readback wrong");

   // Write then read returns the start mode bit
   a_mode_readback: assert property (@(posedge MCLK) disable iff (!RSTN)
      write_reg_s ##1 read_reg_s |=> RDATA[RX_MODE_BIT] == $past(WDATA[RX_MODE_BIT], 2))
      else $error("start mode readback wrong");

   // Writes elsewhere leave the register alone
   a_stray_write: assert property (@(posedge MCLK) disable iff (!RSTN)
      stray_write_s |=> $stable(readback))
      else $error("unmapped write changed the register");

   // Reads elsewhere return zero
   a_stray_read: assert property (@(posedge MCLK) disable iff (!RSTN)
      stray_read_s |=> RDATA == 32'h0000_0000)
      else $error("unmapped read returned data");

   // Reading never disturbs the register
   a_read_quiet: assert property (@(posedge MCLK) disable iff (!RSTN)
      read_reg_s |=> $stable(readback))
      else $error("register read changed the register");

   // Read data are zero unless a read came just before
   a_rdata_idle: assert property (@(posedge MCLK) disable iff (!RSTN)
      !$past(RD) |-> RDATA == 32'h0000_0000)
      else $error("read data outside the read answer cycle");

   // Reserved bits always read zero
   a_reserved_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
      RDATA[31:TX_ENABLE_BIT + 1] == '0 && RDATA[TX_ENABLE_BIT - 1:RX_MODE_BIT + 1] == '0)
      else $error("reserved read data bits not zero");

endmodule // checksum_offload_control

//--- sim/test_checksum_offload_control.sv
`timescale 1ns/1ns
module test_checksum_offload_control
   import checksum_offload_pkg::*;
;
   // Design ports, all driven from time zero
   logic        MCLK = 1'b0;
   logic        RSTN = 1'b0;
   logic [11:0] ADDR = 12'h000;
   logic [31:0] WDATA = 32'h0000_0000;
   logic        WR = 1'b0, RD = 1'b0, TX_SOF = 1'b0, RX_SOF = 1'b0, RX_BYTE_VALID = 1'b0;
   logic [7:0]  RX_BYTE = 8'h00;
   logic [31:0] RDATA;
   logic        TX_ENGINE_ENABLE, RX_ENGINE_ENABLE, RX_L3_MODE;
   logic [7:0]  RX_CHECKSUM_START;
   // Expectation queues and bench model of register and latched settings
   logic        rd_d = 1'b0, probe = 1'b0;
   logic [31:0] rq[$];
   logic [10:0] cq[$];
   logic [7:0]  fb[32];
   logic [31:0] sw_reg = 32'h0000_0000;
   logic [10:0] cur = {3'h0, FIXED_START_OFFSET};
   logic [55:0] cases[5] = '{{16'h0800, 16'h0800, 16'h0800, 8'h0e},
      {16'h8100, 16'h0800, 16'h0800, 8'h12}, {16'h8100, 16'h8100, 16'h0800, 8'h16},
      {16'h0040, 16'h0800, 16'h0800, 8'h16}, {16'h8100, 16'h0040, 16'h0800, 8'h1a}};
   int          mismatches = 0, n_tests = 0, cyc = 0, seed = 58029;
   localparam logic [11:0] A = CHECKSUM_OFFLOAD_CONTROL_ADDR;

   checksum_offload_control dut_u (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .TX_SOF(TX_SOF), .RX_SOF(RX_SOF),
      .RX_BYTE_VALID(RX_BYTE_VALID), .RX_BYTE(RX_BYTE), .TX_ENGINE_ENABLE(TX_ENGINE_ENABLE),
      .RX_ENGINE_ENABLE(RX_ENGINE_ENABLE), .RX_L3_MODE(RX_L3_MODE),
      .RX_CHECKSUM_START(RX_CHECKSUM_START));

   // 250 MHz clock
   always #2 MCLK = ~MCLK;

   task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD read t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic cmp_cfg(input logic [10:0] e, input logic [10:0] g);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD config t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Monitor: read data one cycle after the strobe, settings on a probe, plus timeout
   always @(posedge MCLK)
   begin
      rd_d <= RD;
      if (rd_d)
         cmp_rd(rq.pop_front(), RDATA);
      if (probe)
         cmp_cfg(cq.pop_front(), {TX_ENGINE_ENABLE, RX_ENGINE_ENABLE, RX_L3_MODE,
                                  RX_CHECKSUM_START});
      cyc++;
      if (cyc == 3000)
      begin
         mismatches++;
         final_report();
      end
   end

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge MCLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      if (a == A)
         sw_reg = d & 32'h0001_0003;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      ADDR <= a;
      RD   <= 1'b1;
      rq.push_back(e);
      @(posedge MCLK);
      RD <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic chk_cfg();
      probe <= 1'b1;
      cq.push_back(cur);
      @(posedge MCLK);
      probe <= 1'b0;
   endtask

   task automatic tx_frame();
      @(posedge MCLK);
      TX_SOF <= 1'b1;
      @(posedge MCLK);
      TX_SOF <= 1'b0;
      cur[10] = sw_reg[16];
      chk_cfg();
   endtask

   // Sends a 32-byte frame with type words at bytes 12, 16 and 20
   task automatic rx_frame(input logic [55:0] c);
      for (int i = 0; i < 32; i++)
         fb[i] = 8'($random(seed));
      {fb[12], fb[13], fb[16], fb[17], fb[20], fb[21]} = c[55:8];
      cur[9:0] = {sw_reg[0], sw_reg[1], sw_reg[1] ? c[7:0] : FIXED_START_OFFSET};
      @(posedge MCLK);
      RX_SOF        <= 1'b1;
      RX_BYTE_VALID <= 1'b1;
      for (int i = 0; i < 32; i++)
      begin
         RX_BYTE <= fb[i];
         @(posedge MCLK);
         RX_SOF <= 1'b0;
      end
      RX_BYTE_VALID <= 1'b0;
      repeat (3) @(posedge MCLK);
      chk_cfg();
   endtask

   // Main sequence
   initial
   begin
      repeat (4) @(posedge MCLK);
      RSTN <= 1'b1;
      chk_cfg();
      rd(A, 32'h0000_0000);
      $display("test reset done");
      for (int k = 0; k < 8; k++)
      begin
         wr(A, 32'($random(seed)));
         rd(A, sw_reg);
      end
      wr(12'h134, 32'hffff_ffff);
      rd(12'h134, 32'h0000_0000);
      rd(A, sw_reg);
      $display("test register done");
      wr(A, 32'h0001_0001);
      chk_cfg();
      tx_frame();
      rx_frame(cases[1]);
      wr(A, 32'h0000_0003);
      tx_frame();
      for (int k = 0; k < 5; k++)
         rx_frame(cases[k]);
      wr(A, 32'h0001_0000);
      chk_cfg();
      rx_frame(cases[2]);
      $display("test frames done");
      repeat (2) @(posedge MCLK);
      final_report();
   end
endmodule // test_checksum_offload_control
